// ==== hw/ttc_transport_ctrl.sv ====
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "ttc_defines.svh"
// ****************************************
// tape transport command and status logic
// ****************************************
// What this block does
// - nineteen command codes recognised; each runs only its own function
// - parameter is written before the command code that uses it
// - code 0 returns status byte: head, moving, wind, fast, play, record
// - status and counter reads never report an error
// - code 1 returns the 16-bit position counter
// - counter counts up moving forward, down moving backward
// - code 2 loads the counter from the parameter, returns nothing
// - code 3 stops the motor, returns nothing
// - code 4 runs play; read data passed only with head loaded
// - code 5 runs record, returns nothing
// - record with head loaded erases tape
// - rewind commands unload the head
module ttc_transport_ctrl
  import ttc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CNT_W = 16
) (
  input wire logic aclk, // 20 MHz clock
  input wire logic aresetn, // sync reset
  input wire logic [ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic tape_pulse, // position sensor count
  input wire logic head_rd_data, // raw head read signal
  output logic motor_on, // motor running
  output logic motor_fwd, // forward direction
  output logic motor_fast, // fast speed
  output logic head_load, // head loaded
  output logic erase_en, // erase head on
  output logic read_data // gated read data
);
  // ****************************************
  // bus slave state
  // ****************************************
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic aw_have_r, w_have_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r, rdata_r, rd_mux;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  logic do_write, wr_hit, rd_hit;

  // ****************************************
  // command state
  // ****************************************
  logic [CNT_W-1:0] param_r, count;
  ttc_code_t cmd_code_r;
  logic cmd_go_r, head_r, known, cnt_load, step_up, step_dn;
  ttc_motion_t motion_r;
  logic [31:0] result_r;
  logic [7:0] err_pri_r, err_sec_r, stat_byte;
  logic motor_on_r, motor_fwd_r, motor_fast_r, head_load_r, erase_en_r, read_data_r;

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign motor_on = motor_on_r;
  assign motor_fwd = motor_fwd_r;
  assign motor_fast = motor_fast_r;
  assign head_load = head_load_r;
  assign erase_en = erase_en_r;
  assign read_data = read_data_r;

  assign do_write = aw_have_r && w_have_r && !bvalid_r;
  assign wr_hit = (aw_addr_r == ADDR_W'(`TTC_OFF_CMD)) || (aw_addr_r == ADDR_W'(`TTC_OFF_PARAM));

  // ****************************************
  // write channels
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `TTC_RESP_OKAY;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else begin
      if (awvalid && awready_r) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= awaddr;
        awready_r <= 1'b0;
      end
      if (wvalid && wready_r) begin
        w_have_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
        wready_r <= 1'b0;
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `TTC_RESP_OKAY : `TTC_RESP_SLVERR;
      end
      if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // parameter register, low two byte lanes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      param_r <= CNT_W'(`TTC_CNT_RST);
    end else if (do_write && aw_addr_r == ADDR_W'(`TTC_OFF_PARAM)) begin
      if (w_strb_r[0]) begin
        param_r[7:0] <= w_data_r[7:0];
      end
      if (w_strb_r[1]) begin
        param_r[CNT_W-1:8] <= w_data_r[CNT_W-1:8];
      end
    end
  end

  // writing the code byte launches the command
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_go_r <= 1'b0;
      cmd_code_r <= `TTC_C_READ_STATUS;
    end else begin
      cmd_go_r <= do_write && aw_addr_r == ADDR_W'(`TTC_OFF_CMD) && w_strb_r[0];
      if (do_write && aw_addr_r == ADDR_W'(`TTC_OFF_CMD) && w_strb_r[0]) begin
        cmd_code_r <= w_data_r[7:0];
      end
    end
  end

  // ****************************************
  // command decode
  // ****************************************
  assign known = (cmd_code_r <= `TTC_C_LAST_LOW) || (cmd_code_r == `TTC_C_WP_QUERY);
  assign cnt_load = cmd_go_r && cmd_code_r == `TTC_C_LOAD_COUNT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      motion_r <= MOT_STOP;
    end else if (cmd_go_r) begin
      case (cmd_code_r)
        `TTC_C_HALT: motion_r <= MOT_STOP;
        `TTC_C_PLAY: motion_r <= MOT_PLAY;
        `TTC_C_RECORD: motion_r <= MOT_REC;
        `TTC_C_FAST_FWD, `TTC_C_FWD_TO_END: motion_r <= MOT_FF;
        `TTC_C_SLOW_REW: motion_r <= MOT_SREW;
        `TTC_C_REWIND, `TTC_C_REW_TO_START: motion_r <= MOT_REW;
        default: motion_r <= motion_r;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      head_r <= 1'b0;
    end else if (cmd_go_r) begin
      case (cmd_code_r)
        `TTC_C_HEAD_ON: head_r <= 1'b1;
        `TTC_C_HEAD_OFF: head_r <= 1'b0;
        `TTC_C_SLOW_REW, `TTC_C_REWIND, `TTC_C_REW_TO_START: head_r <= 1'b0;
        default: head_r <= head_r;
      endcase
    end
  end

  // only the two reads produce a result word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_r <= '0;
    end else if (cmd_go_r && cmd_code_r == `TTC_C_READ_STATUS) begin
      result_r <= {24'h000000, stat_byte};
    end else if (cmd_go_r && cmd_code_r == `TTC_C_READ_COUNT) begin
      result_r <= {{(32 - CNT_W){1'b0}}, count};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_pri_r <= `TTC_ERR_NONE;
      err_sec_r <= `TTC_ERR_NONE;
    end else if (cmd_go_r) begin
      err_pri_r <= known ? `TTC_ERR_NONE : `TTC_ERR_UNKNOWN;
      err_sec_r <= `TTC_ERR_NONE;
    end
  end

  // ****************************************
  // status byte and position counter
  // ****************************************
  always_comb begin
    stat_byte = `TTC_STAT_RST;
    stat_byte[`TTC_SB_HEAD] = head_r;
    stat_byte[`TTC_SB_MOVING] = motion_r != MOT_STOP;
    stat_byte[`TTC_SB_WIND] = motion_r == MOT_SREW || motion_r == MOT_REW;
    stat_byte[`TTC_SB_FAST] = motion_r == MOT_FF;
    stat_byte[`TTC_SB_PLAY] = motion_r == MOT_PLAY;
    stat_byte[`TTC_SB_REC] = motion_r == MOT_REC;
  end

  assign step_up = tape_pulse && (motion_r == MOT_PLAY || motion_r == MOT_REC
                   || motion_r == MOT_FF);
  assign step_dn = tape_pulse && (motion_r == MOT_SREW || motion_r == MOT_REW);

  ttc_pos_counter #(
    .W(CNT_W)
  ) u_cnt (
    .aclk(aclk),
    .aresetn(aresetn),
    .load_en(cnt_load),
    .load_val(param_r),
    .step_up(step_up),
    .step_dn(step_dn),
    .count(count)
  );

  // ****************************************
  // transport pins
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      motor_on_r <= 1'b0;
      motor_fwd_r <= 1'b0;
      motor_fast_r <= 1'b0;
      head_load_r <= 1'b0;
    end else begin
      motor_on_r <= motion_r != MOT_STOP;
      motor_fwd_r <= motion_r == MOT_PLAY || motion_r == MOT_REC || motion_r == MOT_FF;
      motor_fast_r <= motion_r == MOT_FF || motion_r == MOT_REW;
      head_load_r <= head_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erase_en_r <= 1'b0;
      read_data_r <= 1'b0;
    end else begin
      erase_en_r <= motion_r == MOT_REC && head_r;
      read_data_r <= head_rd_data && head_r && motion_r == MOT_PLAY;
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  always_comb begin
    rd_hit = 1'b1;
    rd_mux = '0;
    case (araddr)
      ADDR_W'(`TTC_OFF_CMD): rd_mux = {24'h000000, cmd_code_r};
      ADDR_W'(`TTC_OFF_PARAM): rd_mux = {{(32 - CNT_W){1'b0}}, param_r};
      ADDR_W'(`TTC_OFF_STAT): rd_mux = {24'h000000, stat_byte};
      ADDR_W'(`TTC_OFF_RESULT): rd_mux = result_r;
      ADDR_W'(`TTC_OFF_COUNT): rd_mux = {{(32 - CNT_W){1'b0}}, count};
      ADDR_W'(`TTC_OFF_ERR): rd_mux = {16'h0000, err_sec_r, err_pri_r};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `TTC_RESP_OKAY;
    end else if (arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_hit ? `TTC_RESP_OKAY : `TTC_RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence go_s(ttc_code_t c);
    cmd_go_r && cmd_code_r == c;
  endsequence

  sequence stopped_s;
    motion_r == MOT_STOP ##1 !motor_on_r;
  endsequence

  sequence recording_s;
    motion_r == MOT_REC ##1 motor_on_r;
  endsequence

  code_decode_a: assert property (
    cmd_go_r |=> err_pri_r == ($past(known) ? `TTC_ERR_NONE : `TTC_ERR_UNKNOWN))
    else $error("error code does not match command validity");
  param_no_go_a: assert property (
    do_write && aw_addr_r == ADDR_W'(`TTC_OFF_PARAM) |=> !cmd_go_r)
    else $error("parameter write launched a command");
  status_read_a: assert property (
    go_s(`TTC_C_READ_STATUS) |=> result_r[7:0] == $past(stat_byte))
    else $error("status byte not returned");
  read_no_err_a: assert property (
    go_s(`TTC_C_READ_STATUS) or go_s(`TTC_C_READ_COUNT)
      |=> err_pri_r == `TTC_ERR_NONE && err_sec_r == `TTC_ERR_NONE)
    else $error("read command reported an error");
  count_read_a: assert property (
    go_s(`TTC_C_READ_COUNT) |=> result_r[CNT_W-1:0] == $past(count))
    else $error("counter value not returned");
  count_load_a: assert property (
    go_s(`TTC_C_LOAD_COUNT) |=> count == $past(param_r) && $stable(result_r))
    else $error("counter load wrong");
  halt_motor_a: assert property (
    go_s(`TTC_C_HALT) |=> stopped_s)
    else $error("motor not stopped");
  play_gate_a: assert property (
    read_data_r |-> $past(head_r) && $past(motion_r) == MOT_PLAY)
    else $error("read data passed without head in play");
  record_run_a: assert property (
    go_s(`TTC_C_RECORD) |=> recording_s)
    else $error("record mode not entered");
  erase_on_a: assert property (
    motion_r == MOT_REC && head_r |=> erase_en_r)
    else $error("erase missing while recording");
  rewind_head_a: assert property (
    go_s(`TTC_C_SLOW_REW) or go_s(`TTC_C_REWIND) or go_s(`TTC_C_REW_TO_START)
      |=> !head_r ##1 !head_load_r)
    else $error("head not unloaded on rewind");
  count_stop_a: assert property (
    motion_r == MOT_STOP && !cnt_load |=> $stable(count))
    else $error("counter moved while stopped");
  write_resp_a: assert property (
    aw_have_r && w_have_r && !bvalid_r |=> bvalid_r)
    else $error("write response late");
endmodule : ttc_transport_ctrl

// ==== include/ttc_defines.svh ====
`ifndef TTC_DEFINES_SVH
`define TTC_DEFINES_SVH
// ****************************************
// register byte offsets
// ****************************************
`define TTC_OFF_CMD 8'h00
`define TTC_OFF_PARAM 8'h04
`define TTC_OFF_STAT 8'h08
`define TTC_OFF_RESULT 8'h0C
`define TTC_OFF_COUNT 8'h10
`define TTC_OFF_ERR 8'h14
// ****************************************
// command codes
// ****************************************
`define TTC_C_READ_STATUS 8'h00
`define TTC_C_READ_COUNT 8'h01
`define TTC_C_LOAD_COUNT 8'h02
`define TTC_C_HALT 8'h03
`define TTC_C_PLAY 8'h04
`define TTC_C_RECORD 8'h05
`define TTC_C_FAST_FWD 8'h06
`define TTC_C_SLOW_REW 8'h07
`define TTC_C_REWIND 8'h08
`define TTC_C_FWD_TO_END 8'h09
`define TTC_C_REW_TO_START 8'h0A
`define TTC_C_HEAD_ON 8'h0B
`define TTC_C_HEAD_OFF 8'h0C
`define TTC_C_LAST_LOW 8'h11
`define TTC_C_WP_QUERY 8'h14
// ****************************************
// status byte bit positions
// ****************************************
`define TTC_SB_HEAD 7
`define TTC_SB_MOVING 6
`define TTC_SB_WIND 5
`define TTC_SB_FAST 4
`define TTC_SB_PLAY 3
`define TTC_SB_REC 2
// ****************************************
// answers and reset values
// ****************************************
`define TTC_RESP_OKAY 2'h0
`define TTC_RESP_SLVERR 2'h2
`define TTC_ERR_NONE 8'h00
`define TTC_ERR_UNKNOWN 8'hFE
`define TTC_CNT_RST 16'h0000
`define TTC_STAT_RST 8'h00
`endif

// ==== include/ttc_pkg.sv ====
package ttc_pkg;
  typedef enum logic [2:0] {
    MOT_STOP = 3'h0,
    MOT_PLAY = 3'h1,
    MOT_REC = 3'h3,
    MOT_FF = 3'h2,
    MOT_SREW = 3'h6,
    MOT_REW = 3'h7
  } ttc_motion_t;
  typedef logic [7:0] ttc_code_t;
endpackage : ttc_pkg

// ==== hw/ttc_pos_counter.sv ====
`timescale 1ns/10ps
`include "ttc_defines.svh"
module ttc_pos_counter #(
  parameter int W = 16
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset
  input wire logic load_en, // load request
  input wire logic [W-1:0] load_val, // value to load
  input wire logic step_up, // forward count
  input wire logic step_dn, // backward count
  output logic [W-1:0] count // position
);
  logic [W-1:0] count_r;

  assign count = count_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= W'(`TTC_CNT_RST);
    end else if (load_en) begin
      count_r <= load_val;
    end else if (step_up) begin
      count_r <= count_r + W'(1);
    end else if (step_dn) begin
      count_r <= count_r - W'(1);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  count_up_a: assert property (
    step_up && !load_en |=> count_r == $past(count_r) + W'(1))
    else $error("counter did not step up");
  count_dn_a: assert property (
    step_dn && !step_up && !load_en |=> count_r == $past(count_r) - W'(1))
    else $error("counter did not step down");
  count_hold_a: assert property (
    !step_up && !step_dn && !load_en |=> $stable(count_r))
    else $error("counter moved while idle");
endmodule : ttc_pos_counter

// ==== testbench/ttc_tape_model.sv ====
`timescale 1ns/10ps
module ttc_tape_model #(
  parameter int PERIOD = 5
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset
  input wire logic run, // bench lets tape advance
  input wire logic motor_on, // motor running
  output logic tape_pulse, // one position count
  output logic head_rd_data // raw head signal
);
  int div_r;
  logic [7:0] pat_r;
  // ****************************************
  // position sensor: counts only while the motor turns
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 0;
      tape_pulse <= 1'b0;
    end else begin
      div_r <= (div_r == PERIOD - 1) ? 0 : div_r + 1;
      tape_pulse <= run && motor_on && (div_r == 0);
    end
  end
  // ****************************************
  // head signal takes a new pseudo-random bit every cycle so stale data shows
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pat_r <= 8'hA5;
    end else begin
      pat_r <= {pat_r[6:0], pat_r[7] ^ pat_r[5] ^ pat_r[4] ^ pat_r[3]};
    end
  end
  assign head_rd_data = pat_r[0];
endmodule : ttc_tape_model

// ==== testbench/testbench.sv ====
`timescale 1ns/10ps
`include "ttc_defines.svh"
module testbench;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, run;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, mot_e;
  logic [31:0] wdata, rdata, seed;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic tape_pulse, head_rd_data, motor_on, motor_fwd, motor_fast;
  logic head_load, erase_en, read_data, head_e, fast_e;
  logic [15:0] cnt_e, par_e;
  int n_errors, checked, n_pulse;
  logic [7:0] codes [26] = '{8'h00, 8'h02, 8'h0B, 8'h04, 8'h05, 8'h03, 8'h0C, 8'h05, 8'h06, 8'h09,
    8'h0B, 8'h07, 8'h03, 8'h0B, 8'h08, 8'h0A, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11,
    8'h14, 8'h12, 8'h13, 8'hFF, 8'h01};

  ttc_transport_ctrl u_ttc_transport_ctrl (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .tape_pulse(tape_pulse), .head_rd_data(head_rd_data),
    .motor_on(motor_on), .motor_fwd(motor_fwd), .motor_fast(motor_fast),
    .head_load(head_load), .erase_en(erase_en), .read_data(read_data));
  ttc_tape_model u_ttc_tape_model (.aclk(aclk), .aresetn(aresetn), .run(run),
    .motor_on(motor_on), .tape_pulse(tape_pulse), .head_rd_data(head_rd_data));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (tape_pulse === 1'b1) n_pulse++;
  end
  initial begin
    #(50 * 60000);
    n_errors++;
    give_verdict();
  end
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic give_verdict();
    $display("n_errors=%0d checked=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // bready and rready stay high once raised; only the watchdog ends a wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd
  // tape moves n counts; direction follows the commanded mode
  task automatic move(input int n);
    int w;
    w = 0;
    n_pulse = 0;
    run <= 1'b1;
    while (n_pulse < n && w < 100 * n) begin
      @(posedge aclk);
      w++;
    end
    run <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({31'h0, n_pulse >= n}, 32'h1);
    cnt_e = mot_e[5] ? cnt_e - 16'(n_pulse) : cnt_e + 16'(n_pulse);
    rd(`TTC_OFF_COUNT, {16'h0, cnt_e}, `TTC_RESP_OKAY);
  endtask : move
  task automatic cmd(input logic [7:0] c);
    logic [7:0] st;
    wr(`TTC_OFF_CMD, {24'h0, c}, `TTC_RESP_OKAY);
    case (c)
      8'h02: cnt_e = par_e;
      8'h03: mot_e = 8'h00;
      8'h04: mot_e = 8'h48;
      8'h05: mot_e = 8'h44;
      8'h06, 8'h09: mot_e = 8'h50;
      8'h07, 8'h08, 8'h0A: begin
        mot_e = 8'h60;
        head_e = 1'b0;
      end
      8'h0B: head_e = 1'b1;
      8'h0C: head_e = 1'b0;
      default: ;
    endcase
    if (c >= 8'h03 && c <= 8'h0A) fast_e = c inside {8'h06, 8'h08, 8'h09, 8'h0A};
    st = {head_e, mot_e[6:0]};
    rd(`TTC_OFF_ERR, (c <= 8'h11 || c == 8'h14) ? 32'h0 : 32'hFE, `TTC_RESP_OKAY);
    rd(`TTC_OFF_STAT, {24'h0, st}, `TTC_RESP_OKAY);
    if (c == 8'h00) rd(`TTC_OFF_RESULT, {24'h0, st}, `TTC_RESP_OKAY);
    if (c == 8'h01) rd(`TTC_OFF_RESULT, {16'h0, cnt_e}, `TTC_RESP_OKAY);
    rd(`TTC_OFF_COUNT, {16'h0, cnt_e}, `TTC_RESP_OKAY);
    chk({motor_on, motor_fwd, motor_fast, head_load, erase_en}, {mot_e[6], mot_e[6] & ~mot_e[5],
      fast_e, head_e, mot_e[2] & head_e});
  endtask : cmd
  task automatic step(input logic [7:0] c);
    logic [31:0] p;
    if (c == 8'h0B && mot_e[5]) c = 8'h03;
    if (c == 8'h02) begin
      p = xs();
      par_e = p[15:0];
      wr(`TTC_OFF_PARAM, {16'h0, par_e}, `TTC_RESP_OKAY);
    end
    // block transfers: host keeps length and buffer pointer in range
    if (c inside {8'h10, 8'h11}) begin
      p = xs();
      wr(`TTC_OFF_PARAM, {16'h0, 16'h0004 + p[15:0] % 16'h010B}, `TTC_RESP_OKAY);
      wr(`TTC_OFF_PARAM, {16'h0, 1'b1, p[30:16]}, `TTC_RESP_OKAY);
      rd(`TTC_OFF_PARAM, {16'h0, 1'b1, p[30:16]}, `TTC_RESP_OKAY);
    end
    cmd(c);
    if (mot_e[6]) move(1 + int'(xs() % 3));
  endtask : step
  task automatic gate_chk(input logic on);
    logic prev;
    @(posedge aclk);
    prev = head_rd_data;
    repeat (8) begin
      @(posedge aclk);
      chk({31'h0, read_data}, {31'h0, prev & on});
      prev = head_rd_data;
    end
  endtask : gate_chk
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, run} = 7'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    {n_errors, checked, n_pulse} = {32'h0, 32'h0, 32'h0};
    {mot_e, head_e, fast_e, cnt_e, par_e} = 42'h0;
    seed = 32'h12AE;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`TTC_OFF_STAT, 32'h0, `TTC_RESP_OKAY);
    rd(`TTC_OFF_COUNT, 32'h0, `TTC_RESP_OKAY);
    rd(`TTC_OFF_ERR, 32'h0, `TTC_RESP_OKAY);
    rd(8'h18, 32'h0, `TTC_RESP_SLVERR);
    wr(`TTC_OFF_STAT, 32'hFF, `TTC_RESP_SLVERR);
    par_e = 16'hFFFE;
    wr(`TTC_OFF_PARAM, {16'h0, par_e}, `TTC_RESP_OKAY);
    rd(`TTC_OFF_PARAM, {16'h0, par_e}, `TTC_RESP_OKAY);
    cmd(8'h02);
    cmd(8'h04);
    move(3);
    cmd(8'h08);
    move(3);
    cmd(8'h03);
    run <= 1'b1;
    repeat (30) @(posedge aclk);
    run <= 1'b0;
    rd(`TTC_OFF_COUNT, {16'h0, cnt_e}, `TTC_RESP_OKAY);
    cmd(8'h0B);
    cmd(8'h04);
    gate_chk(1'b1);
    cmd(8'h0C);
    gate_chk(1'b0);
    foreach (codes[i]) step(codes[i]);
    repeat (40) step(8'(xs() % 24));
    give_verdict();
  end
endmodule : testbench
